// File: dv/hsis_host_model.sv
// spi master model of the host controller
`timescale 1ns/1ps
module hsis_host_model (
    input  wire logic core_clk,
    input  wire logic miso,
    output logic      cs_n,
    output logic      sck,
    output logic      mosi
);
    int half = 8; // core_clk cycles per sck half period

    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        mosi = 1'b1;
    end

    task automatic start_frame();
        @(posedge core_clk);
        cs_n <= 1'b0;
        repeat (half) @(posedge core_clk);
    endtask

    // one byte, msb first: change on the fall, sample on the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck  <= 1'b0;
            mosi <= tx[i];
            repeat (half) @(posedge core_clk);
            sck   <= 1'b1;
            rx[i] = miso;
            repeat (half) @(posedge core_clk);
        end
    endtask

    task automatic end_frame();
        sck <= 1'b0;
        repeat (half) @(posedge core_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi; // released line shows no stale level
        repeat (half) @(posedge core_clk);
    endtask
endmodule // hsis_host_model

// File: dv/hsis_sva.sv
// assertions on the ports of the host interface select block
`timescale 1ns/1ps
module hsis_sva (
    input wire logic                    core_clk,
    input wire logic                    sys_rst,
    input wire hsis_pkg::hsis_mode_e    host_if_mode,
    input wire hsis_pkg::hsis_reg_req_s reg_req,
    input wire logic                    uart_rx,
    input wire logic                    d5_oe,
    input wire logic                    d6_oe,
    input wire logic                    serial_line_enable,
    input wire logic                    speed_wr,
    input wire logic [7:0]              speed_wr_data,
    input wire logic [7:0]              serial_speed_register,
    input wire logic                    uart_baud_tick
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_mode_held: assert property (
        $past(host_if_mode) != hsis_pkg::HSIS_DETECT |-> $stable(host_if_mode))
        else $error("interface mode changed after detection");
    a_rx_idle: assert property (
        host_if_mode != hsis_pkg::HSIS_UART |=> uart_rx)
        else $error("uart receive not idle outside uart mode");
    a_oe_mode: assert property (
        host_if_mode != hsis_pkg::HSIS_UART |=> !d5_oe && !d6_oe)
        else $error("uart side pins driven outside uart mode");
    a_line_off: assert property (
        !serial_line_enable |=> !d5_oe && !d6_oe)
        else $error("rts or aux driven while line disabled");
    a_req_spi_only: assert property (
        reg_req.wr || reg_req.rd |->
            host_if_mode == hsis_pkg::HSIS_SPI && !(reg_req.wr && reg_req.rd))
        else $error("bad register request");
    a_req_pulse: assert property (
        reg_req.wr || reg_req.rd |=> !reg_req.wr && !reg_req.rd)
        else $error("register request longer than one cycle");
    a_speed_load: assert property (
        speed_wr |=> serial_speed_register == $past(speed_wr_data))
        else $error("speed register not loaded");
    a_speed_hold: assert property (
        !speed_wr |=> $stable(serial_speed_register))
        else $error("speed register changed without a write");
    a_tick_uart: assert property (
        uart_baud_tick |-> host_if_mode == hsis_pkg::HSIS_UART)
        else $error("baud tick outside uart mode");
endmodule // hsis_sva

bind hsis_top hsis_sva chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .host_if_mode(host_if_mode), .reg_req(reg_req),
    .uart_rx(uart_rx), .d5_oe(d5_oe), .d6_oe(d6_oe), .serial_line_enable(serial_line_enable),
    .speed_wr(speed_wr), .speed_wr_data(speed_wr_data),
    .serial_speed_register(serial_speed_register), .uart_baud_tick(uart_baud_tick)
);

// File: dv/test_host_serial_interface_select.sv
// self-checking bench for the host interface select block
`timescale 1ns/1ps
module test_host_serial_interface_select;
    logic                     core_clk, sys_rst, i2c_select_pin, addr_mode_pin;
    logic                     spi_on, rx_line, serial_line_enable, speed_wr;
    logic [7:5]               pins;
    logic [7:0]               speed_wr_data, reg_rd_data, serial_speed_register;
    hsis_pkg::hsis_uart_out_s uart_out;
    logic                     d7_out, d7_oe, d6_out, d6_oe, d5_out, d5_oe;
    logic                     uart_rx, i2c_scl, uart_baud_tick, cs_n, sck, mosi;
    logic                     data_pin, d5_in, d6_in, d7_in;
    logic [1:0]               i2c_addr_low;
    hsis_pkg::hsis_mode_e     host_if_mode;
    hsis_pkg::hsis_reg_req_s  reg_req;
    logic [13:0]              wr_log[$];
    logic [5:0]               rd_log[$];
    logic [7:0]               speeds[5] = '{8'h00, 8'h1c, 8'h3a, 8'h5a, 8'hff};
    int                       failures = 0;
    int                       check_count = 0;

    assign data_pin    = spi_on ? cs_n : rx_line;
    assign d5_in       = spi_on ? sck : pins[5];
    assign d6_in       = spi_on ? mosi : pins[6];
    assign d7_in       = d7_oe ? d7_out : pins[7];
    assign reg_rd_data = {reg_req.addr, 2'h1} ^ 8'h5a;

    hsis_top uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .data_pin(data_pin),
        .i2c_select_pin(i2c_select_pin), .addr_mode_pin(addr_mode_pin),
        .d7_in(d7_in), .d6_in(d6_in), .d5_in(d5_in), .d7_out(d7_out), .d7_oe(d7_oe),
        .d6_out(d6_out), .d6_oe(d6_oe), .d5_out(d5_out), .d5_oe(d5_oe),
        .host_if_mode(host_if_mode), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
        .uart_out(uart_out), .uart_rx(uart_rx), .serial_line_enable(serial_line_enable),
        .speed_wr(speed_wr), .speed_wr_data(speed_wr_data),
        .serial_speed_register(serial_speed_register), .uart_baud_tick(uart_baud_tick),
        .i2c_addr_low(i2c_addr_low), .i2c_scl(i2c_scl)
    );
    hsis_host_model host (
        .core_clk(core_clk), .miso(d7_in), .cs_n(cs_n), .sck(sck), .mosi(mosi)
    );

    always #10 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        if (reg_req.wr === 1'b1)
            wr_log.push_back({reg_req.addr, reg_req.data});
        if (reg_req.rd === 1'b1)
            rd_log.push_back(reg_req.addr);
    end

    function automatic logic [7:0] exp_rd(input logic [5:0] a);
        return {a, 2'h1} ^ 8'h5a;
    endfunction

    function automatic int divisor(input logic [7:0] v);
        int f;
        f = (v[7:5] < 3'h2) ? 1 : (1 << (v[7:5] - 1));
        return f * ((v[7:5] == 3'h0) ? v[4:0] + 1 : v[4:0] + 33);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        check_count++;
        if (seen !== want)
        begin
            failures++;
            $display("FAIL %0t %s: got %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic do_reset(input logic i2c, input logic ea, input logic spi);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        i2c_select_pin <= i2c;
        addr_mode_pin <= ea;
        spi_on <= spi;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (12) @(posedge core_clk);
    endtask

    // cycles between two baud ticks
    task automatic measure(output int n);
        int k;
        k = 0;
        @(negedge core_clk);
        while (uart_baud_tick !== 1'b1)
        begin
            k++;
            if (k > 5000)
            begin
                failures++;
                end_of_test();
            end
            @(negedge core_clk);
        end
        n = 0;
        do
        begin
            n++;
            @(negedge core_clk);
        end while (uart_baud_tick !== 1'b1 && n < 5000);
        if (n >= 5000)
        begin
            failures++;
            end_of_test();
        end
        @(posedge core_clk);
    endtask

    task automatic test_spi();
        logic [7:0] rx;
        do_reset(1'b0, 1'b1, 1'b1);
        check(16'(host_if_mode), 16'(hsis_pkg::HSIS_SPI), "spi mode");
        host.start_frame();
        host.xfer(8'h14, rx); // write, address 0a, bit 0 clear
        host.xfer(8'h3c, rx);
        check(16'(rx), 16'h0, "miso in write");
        host.xfer(8'hc3, rx);
        check(16'(rx), 16'h0, "miso in write");
        host.end_frame();
        check(16'(wr_log[0]), 16'h0a3c, "first write");
        check(16'(wr_log[1]), 16'h0ac3, "second write");
        host.half = 12;
        host.start_frame();
        host.xfer(8'h86, rx); // read address 03
        host.xfer(8'hfe, rx); // read address 3f
        check(16'(rx), 16'(exp_rd(6'h03)), "first read");
        host.xfer(8'h00, rx);
        check(16'(rx), 16'(exp_rd(6'h3f)), "last read");
        host.end_frame();
        check(16'(rd_log.size()), 16'h2, "read count");
        host.half = 3;
        host.start_frame();
        host.xfer(8'h28, rx);
        host.xfer(8'h99, rx);
        host.end_frame();
        check(16'(wr_log[2]), 16'h1499, "fast write");
        host.half = 8;
        host.start_frame();
        host.xfer(8'h8c, rx); // decoded as a fresh address
        host.xfer(8'h00, rx);
        host.end_frame();
        check(16'(rx), 16'(exp_rd(6'h06)), "read after release");
        check(16'(wr_log.size()), 16'h3, "no stray write");
        $display("spi test done");
    endtask

    task automatic test_uart();
        int n;
        do_reset(1'b0, 1'b0, 1'b0);
        check(16'(host_if_mode), 16'(hsis_pkg::HSIS_UART), "uart mode");
        check(16'(serial_speed_register), 16'h00eb, "speed reset");
        measure(n);
        check(16'(n), 16'(divisor(8'heb)), "default baud");
        uart_out <= 3'b110;
        serial_line_enable <= 1'b1;
        rx_line <= 1'b0;
        repeat (8) @(posedge core_clk);
        check(16'({d7_out, d7_oe, d6_out, d6_oe, d5_out, d5_oe, uart_rx}), 16'h7a,
              "uart pins");
        serial_line_enable <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(16'({d6_oe, d5_oe}), 16'h0, "lines off");
        foreach (speeds[i])
        begin
            speed_wr <= 1'b1;
            speed_wr_data <= speeds[i];
            @(posedge core_clk);
            speed_wr <= 1'b0;
            @(posedge core_clk);
            check(16'(serial_speed_register), 16'(speeds[i]), "speed write");
            measure(n);
            check(16'(n), 16'(divisor(speeds[i])), "baud period");
        end
        $display("uart test done");
    endtask

    task automatic test_i2c();
        do_reset(1'b1, 1'b0, 1'b0);
        check(16'(host_if_mode), 16'(hsis_pkg::HSIS_I2C), "i2c mode");
        for (int i = 0; i < 2; i++)
        begin
            pins <= i ? 3'b010 : 3'b101;
            repeat (8) @(posedge core_clk);
            check(16'({i2c_addr_low, i2c_scl, uart_rx}), i ? 16'h5 : 16'hb, "i2c pins");
        end
        $display("i2c test done");
    endtask

    initial
    begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        i2c_select_pin = 1'b0;
        addr_mode_pin = 1'b0;
        spi_on = 1'b0;
        rx_line = 1'b1;
        pins = 3'h0;
        serial_line_enable = 1'b0;
        speed_wr = 1'b0;
        speed_wr_data = 8'h00;
        uart_out = 3'h0;
        test_spi();
        test_uart();
        test_i2c();
        end_of_test();
    end
endmodule // test_host_serial_interface_select

// File: logic/hsis_pkg.sv
// shared constants and types of the host serial interface select block
package hsis_pkg;

    // interface kinds, chosen once after reset
    typedef enum logic [3:0] {
        HSIS_DETECT = 4'b0001,
        HSIS_SPI    = 4'b0010,
        HSIS_UART   = 4'b0100,
        HSIS_I2C    = 4'b1000
    } hsis_mode_e;

    // address byte layout
    localparam int ADDR_DIR_BIT   = 7;
    localparam int ADDR_MSB       = 6;
    localparam int ADDR_LSB       = 1;
    localparam logic DIR_READ     = 1'b1;
    localparam logic [7:0] READ_END_BYTE = 8'h00;
    localparam logic [7:0] DONT_CARE_BYTE = 8'h00;

    // serial speed register layout and reset value (9.6 kBd)
    localparam int SPEED_EXP_MSB  = 7;
    localparam int SPEED_EXP_LSB  = 5;
    localparam int SPEED_MAN_MSB  = 4;
    localparam int SPEED_MAN_LSB  = 0;
    localparam logic [7:0] SERIAL_SPEED_RESET = 8'heb;
    localparam logic [12:0] MAN_OFFSET_EXP0 = 13'h0001;
    localparam logic [12:0] MAN_OFFSET_EXPN = 13'h0021;

    // cycles the pin synchronisers need before the strap pins are trusted
    localparam logic [2:0] DETECT_WAIT = 3'h5;

    // register access request produced by the spi slave
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] data;
    } hsis_reg_req_s;

    // uart side signals supplied by the framing logic
    typedef struct packed {
        logic tx;
        logic aux;
        logic rts;
    } hsis_uart_out_s;

endpackage

// File: logic/hsis_sync3.sv
// three flip-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module hsis_sync3 (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level
);
    logic q1;
    logic q2;
    logic q3;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q1 <= 1'b0;
            q2 <= 1'b0;
            q3 <= 1'b0;
        end
        else
        begin
            q1 <= pin;
            q2 <= q1;
            q3 <= q2;
        end
    end

    // a change counts once the second and third stages agree
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            level <= 1'b0;
        else if (q2 == q3)
            level <= q3;
    end
endmodule // hsis_sync3

// File: logic/hsis_top.sv
// host interface select: strap detection, pin routing, spi slave, uart baud divider
// Notes on behaviour
// - after reset, pick interface from select and address-mode pins anew
// - shared pins take chip select/rx and miso/mosi/sck, tx/aux/rts or i2c roles
// - spi acts only as slave, master makes sck and drives mosi, to 10 Mbit/s
// - bytes shift msb first on mosi and miso
// - sample on sck rising edge, change miso on falling edge
// - burst read: address per byte, 00 ends; reply lags one slot, first don't care
// - write: one address byte then data bytes to that register; miso meaningless
// - address byte: bit 7 read when 1, bits 6..1 address, bit 0 zero
// - uart runs at 9.6 kBd after reset until reprogrammed
// - host writes serial speed register: 3-bit exponent, 5-bit mantissa set divider
// - exponent 0 and 1 give factor 1, then doubling; mantissa span 1..32 or 33..64
// - rts and aux outputs switched off while serial line enable is clear
`timescale 1ns/1ps
module hsis_top (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     data_pin,
    input  wire logic                     i2c_select_pin,
    input  wire logic                     addr_mode_pin,
    input  wire logic                     d7_in,
    input  wire logic                     d6_in,
    input  wire logic                     d5_in,
    output logic                          d7_out,
    output logic                          d7_oe,
    output logic                          d6_out,
    output logic                          d6_oe,
    output logic                          d5_out,
    output logic                          d5_oe,
    output hsis_pkg::hsis_mode_e          host_if_mode,
    output hsis_pkg::hsis_reg_req_s       reg_req,
    input  wire logic [7:0]               reg_rd_data,
    input  wire hsis_pkg::hsis_uart_out_s uart_out,
    output logic                          uart_rx,
    input  wire logic                     serial_line_enable,
    input  wire logic                     speed_wr,
    input  wire logic [7:0]               speed_wr_data,
    output logic [7:0]                    serial_speed_register,
    output logic                          uart_baud_tick,
    output logic [1:0]                    i2c_addr_low,
    output logic                          i2c_scl
);
    logic                 s_data;
    logic                 s_sel;
    logic                 s_ea;
    logic                 s_d7;
    logic                 s_d6;
    logic                 s_d5;
    logic                 sck_d;
    logic [2:0]           wait_cnt;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 cs_active;
    logic [2:0]           bit_cnt;
    logic [7:0]           rx_sh;
    logic [7:0]           tx_sh;
    logic [7:0]           tx_next;
    logic                 first_byte;
    logic                 is_read;
    logic [5:0]           wr_addr;
    logic                 rd_pending;
    logic                 miso;
    logic [7:0]           next_rx;
    logic [12:0]          divisor;
    logic [12:0]          baud_cnt;
    logic [2:0]           speed_exp;
    logic [4:0]           speed_man;
    logic [12:0]          factor;
    logic [12:0]          span;

    hsis_sync3 u_s_data (.core_clk(core_clk), .sys_rst(sys_rst), .pin(data_pin),
                         .level(s_data));
    hsis_sync3 u_s_sel  (.core_clk(core_clk), .sys_rst(sys_rst), .pin(i2c_select_pin),
                         .level(s_sel));
    hsis_sync3 u_s_ea   (.core_clk(core_clk), .sys_rst(sys_rst), .pin(addr_mode_pin),
                         .level(s_ea));
    hsis_sync3 u_s_d7   (.core_clk(core_clk), .sys_rst(sys_rst), .pin(d7_in),
                         .level(s_d7));
    hsis_sync3 u_s_d6   (.core_clk(core_clk), .sys_rst(sys_rst), .pin(d6_in),
                         .level(s_d6));
    hsis_sync3 u_s_d5   (.core_clk(core_clk), .sys_rst(sys_rst), .pin(d5_in),
                         .level(s_d5));

    // strap detection once the synchronisers have settled
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_cnt     <= 3'h0;
            host_if_mode <= hsis_pkg::HSIS_DETECT;
        end
        else
        begin
            case (host_if_mode)
                hsis_pkg::HSIS_DETECT:
                begin
                    if (wait_cnt == hsis_pkg::DETECT_WAIT)
                    begin
                        if (s_sel)
                            host_if_mode <= hsis_pkg::HSIS_I2C;
                        else if (s_ea)
                            host_if_mode <= hsis_pkg::HSIS_SPI;
                        else
                            host_if_mode <= hsis_pkg::HSIS_UART;
                    end
                    else
                        wait_cnt <= wait_cnt + 3'h1;
                end
                hsis_pkg::HSIS_SPI,
                hsis_pkg::HSIS_UART,
                hsis_pkg::HSIS_I2C:
                    host_if_mode <= host_if_mode;
                default:
                    host_if_mode <= hsis_pkg::HSIS_DETECT;
            endcase
        end
    end

    // spi edges, sampled from the synchronised serial clock on d5
    assign cs_active = (host_if_mode == hsis_pkg::HSIS_SPI) && !s_data;
    assign sck_rise  = cs_active && s_d5 && !sck_d;
    assign sck_fall  = cs_active && !s_d5 && sck_d;
    assign next_rx   = {rx_sh[6:0], s_d6};

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sck_d <= 1'b0;
        else
            sck_d <= s_d5;
    end

    // receive side: slave only, master makes sck and drives mosi
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bit_cnt    <= 3'h0;
            rx_sh      <= 8'h00;
            first_byte <= 1'b1;
            is_read    <= 1'b0;
            wr_addr    <= 6'h00;
            reg_req    <= '0;
            rd_pending <= 1'b0;
        end
        else
        begin
            reg_req.wr <= 1'b0;
            reg_req.rd <= 1'b0;
            rd_pending <= reg_req.rd;
            if (!cs_active)
            begin
                bit_cnt    <= 3'h0;
                first_byte <= 1'b1;
            end
            else if (sck_rise)
            begin
                rx_sh   <= next_rx;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7)
                begin
                    first_byte <= 1'b0;
                    if (first_byte)
                    begin
                        is_read <= (next_rx[hsis_pkg::ADDR_DIR_BIT] == hsis_pkg::DIR_READ);
                        wr_addr <= next_rx[hsis_pkg::ADDR_MSB:hsis_pkg::ADDR_LSB];
                    end
                    if ((first_byte && next_rx[hsis_pkg::ADDR_DIR_BIT] == hsis_pkg::DIR_READ)
                        || (!first_byte && is_read && next_rx != hsis_pkg::READ_END_BYTE))
                    begin
                        reg_req.rd   <= 1'b1;
                        reg_req.addr <= next_rx[hsis_pkg::ADDR_MSB:hsis_pkg::ADDR_LSB];
                    end
                    else if (!first_byte && !is_read)
                    begin
                        reg_req.wr   <= 1'b1;
                        reg_req.addr <= wr_addr;
                        reg_req.data <= next_rx;
                    end
                end
            end
        end
    end

    // transmit side: next slot byte and msb-first shifter on falling edges
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_next <= hsis_pkg::DONT_CARE_BYTE;
            tx_sh   <= hsis_pkg::DONT_CARE_BYTE;
            miso    <= 1'b0;
        end
        else if (!cs_active)
        begin
            tx_next <= hsis_pkg::DONT_CARE_BYTE;
            tx_sh   <= hsis_pkg::DONT_CARE_BYTE;
            miso    <= 1'b0;
        end
        else
        begin
            if (rd_pending)
                tx_next <= reg_rd_data;
            else if (sck_rise && bit_cnt == 3'h7)
                tx_next <= hsis_pkg::DONT_CARE_BYTE;
            if (sck_fall)
            begin
                if (bit_cnt == 3'h0)
                begin
                    miso  <= tx_next[7];
                    tx_sh <= {tx_next[6:0], 1'b0};
                end
                else
                begin
                    miso  <= tx_sh[7];
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
            end
        end
    end

    // serial speed register and baud divider
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            serial_speed_register <= hsis_pkg::SERIAL_SPEED_RESET;
        else if (speed_wr)
            serial_speed_register <= speed_wr_data;
    end

    assign speed_exp = serial_speed_register[hsis_pkg::SPEED_EXP_MSB:hsis_pkg::SPEED_EXP_LSB];
    assign speed_man = serial_speed_register[hsis_pkg::SPEED_MAN_MSB:hsis_pkg::SPEED_MAN_LSB];

    always_comb
    begin
        if (speed_exp <= 3'h1)
            factor = 13'h0001;
        else
            factor = 13'h0001 << (speed_exp - 3'h1);
        if (speed_exp == 3'h0)
            span = {8'h00, speed_man} + hsis_pkg::MAN_OFFSET_EXP0;
        else
            span = {8'h00, speed_man} + hsis_pkg::MAN_OFFSET_EXPN;
        divisor = 13'(factor * span);
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            baud_cnt       <= 13'h0000;
            uart_baud_tick <= 1'b0;
        end
        else if (host_if_mode != hsis_pkg::HSIS_UART || baud_cnt >= divisor - 13'h0001)
        begin
            baud_cnt       <= 13'h0000;
            uart_baud_tick <= (host_if_mode == hsis_pkg::HSIS_UART);
        end
        else
        begin
            baud_cnt       <= baud_cnt + 13'h0001;
            uart_baud_tick <= 1'b0;
        end
    end

    // shared pin routing per mode
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            d7_out       <= 1'b0;
            d7_oe        <= 1'b0;
            d6_out       <= 1'b0;
            d6_oe        <= 1'b0;
            d5_out       <= 1'b0;
            d5_oe        <= 1'b0;
            uart_rx      <= 1'b1;
            i2c_addr_low <= 2'h0;
            i2c_scl      <= 1'b1;
        end
        else
        begin
            d7_out       <= 1'b0;
            d7_oe        <= 1'b0;
            d6_out       <= 1'b0;
            d6_oe        <= 1'b0;
            d5_out       <= 1'b0;
            d5_oe        <= 1'b0;
            uart_rx      <= 1'b1;
            i2c_addr_low <= i2c_addr_low;
            i2c_scl      <= 1'b1;
            case (host_if_mode)
                hsis_pkg::HSIS_SPI:
                begin
                    d7_out <= miso;
                    d7_oe  <= cs_active;
                end
                hsis_pkg::HSIS_UART:
                begin
                    uart_rx <= s_data;
                    d7_out  <= uart_out.tx;
                    d7_oe   <= 1'b1;
                    d6_out  <= uart_out.aux;
                    d6_oe   <= serial_line_enable;
                    d5_out  <= uart_out.rts;
                    d5_oe   <= serial_line_enable;
                end
                hsis_pkg::HSIS_I2C:
                begin
                    i2c_scl      <= s_d7;
                    i2c_addr_low <= {s_d5, s_d6};
                end
                default:
                    d7_oe <= 1'b0;
            endcase
        end
    end
endmodule // hsis_top
